// >>> design/dscp_top.sv
// Serial command front end: shift, commit, decode and readback
//
// Behaviour
// [R01] Dual mode: voltage from control, current from config
// [R02] Dual voltage span codes; 1xx disables voltage
// [R03] Forbidden span 100 rejected, old span held
// [R04] Dual current span codes; 00 disables current
// [R05] Modem injection only in 4-20 mA span
// [R06] Link rated to 30 MHz serial clock; the pins are sampled at mclk, so here the link must stay well under mclk/4
// [R07] 24-bit frame, bits taken on rising edges
// [R08] Bits 23:16 address, 15:0 data word
// [R09] Host shifts exactly 24 bits before strobe
// [R10] Shift ignores strobe; strobe rise commits always
// [R11] Shift register clears at reset
// [R12] Address byte decodes the write functions
// [R13] Address 02 starts readback, bits 5:0 select
// [R14] Host follows readback with idle frame
// [R15] Readback value out MSB first, falling edges
// [R16] Low two select bits pick status/data/control
// [R17] Full select match for config, gain, zero
// [R18] Address 55 writes control register
// [R19] Address 01 writes DAC data register
// [R20] Span change clears DAC data by clear select; current spans clear to zero whatever the select
// [R21] Unknown address acts as idle command
`timescale 1ns/10ps
module dscp_top
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Serial link pins
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic frame_strobe,
  output logic serial_out,
  // Fault status from the analog side
  input wire logic [4:0] status_flags,
  // Stored registers
  output logic [15:0] control_word,
  output logic [15:0] config_word,
  output logic [15:0] dac_code,
  output logic [15:0] gain_cal,
  output logic [15:0] zero_cal,
  // Decoded output spans
  output logic voltage_output_enable,
  output logic [2:0] voltage_span,
  output logic current_output_enable,
  output logic [1:0] current_span_select,
  output logic modem_inject_enable,
  // Command pulses
  output logic watchdog_restart,
  output logic crc_error_clear
);
  dscp_link_if link ();
  logic [23:0] shift;
  logic [23:0] out_shift;
  logic [7:0] frame_addr;
  logic [15:0] frame_data;
  logic [15:0] readback;
  logic [15:0] next_control;
  logic [15:0] clear_code;
  logic [2:0] new_range;
  logic dual_output_enable;
  logic soft_reset;

  dscp_sampler u_sampler
  (
    .mclk(mclk),
    .rst(rst),
    .serial_clk(serial_clk),
    .serial_in(serial_in),
    .frame_strobe(frame_strobe),
    .link(link)
  );

  // Sampled at mclk, so the link must stay well under mclk/4 in practice
  // even though the pins are rated higher [R06]
  always_ff @(posedge mclk)
  begin
    if (rst)
      shift <= dscp_pkg::SHIFT_RESET; // [R11]
    else if (link.clk_rise)
      shift <= {shift[dscp_pkg::FRAME_BITS-2:0], link.data_bit}; // [R07] [R10]
  end

  // Frame fields [R08]
  assign frame_addr = shift[dscp_pkg::ADDR_MSB:dscp_pkg::ADDR_LSB];
  assign frame_data = shift[dscp_pkg::WORD_BITS-1:0];
  assign soft_reset = link.strobe_rise
    && frame_addr == dscp_pkg::ADDR_RESET
    && frame_data[dscp_pkg::RST_BIT];
  assign dual_output_enable = config_word[dscp_pkg::CFG_DUAL];

  // Control write keeps the old span on the forbidden code
  always_comb
  begin
    next_control = frame_data;
    if (frame_data[dscp_pkg::CTL_RANGE_MSB:dscp_pkg::CTL_RANGE_LSB]
      == dscp_pkg::RANGE_FORBIDDEN)
      next_control[dscp_pkg::CTL_RANGE_MSB:dscp_pkg::CTL_RANGE_LSB] =
        control_word[dscp_pkg::CTL_RANGE_MSB:dscp_pkg::CTL_RANGE_LSB];
    // [R03]
  end
  assign new_range =
    next_control[dscp_pkg::CTL_RANGE_MSB:dscp_pkg::CTL_RANGE_LSB];

  // Clear value for the new span and clear select
  always_comb
  begin
    clear_code = dscp_pkg::CODE_ZERO;
    if (new_range == dscp_pkg::RANGE_PM5V
      || new_range == dscp_pkg::RANGE_PM10V)
      clear_code = next_control[dscp_pkg::CTL_CLRSEL]
        ? dscp_pkg::CODE_ZERO : dscp_pkg::CODE_MID;
    else if (!new_range[2])
      clear_code = next_control[dscp_pkg::CTL_CLRSEL]
        ? dscp_pkg::CODE_MID : dscp_pkg::CODE_ZERO;
  end

  // Register writes on strobe rise; unknown addresses change nothing
  always_ff @(posedge mclk)
  begin
    if (rst || soft_reset)
    begin
      control_word <= dscp_pkg::REG_RESET;
      config_word <= dscp_pkg::REG_RESET;
      dac_code <= dscp_pkg::REG_RESET;
      gain_cal <= dscp_pkg::REG_RESET;
      zero_cal <= dscp_pkg::REG_RESET;
    end
    else if (link.strobe_rise) // [R10]
    begin
      unique case (frame_addr) // [R12] [R21]
        dscp_pkg::ADDR_DAC_DATA: dac_code <= frame_data; // [R19]
        dscp_pkg::ADDR_CONTROL:
        begin
          control_word <= next_control; // [R18]
          if (new_range != control_word[dscp_pkg::CTL_RANGE_MSB:
            dscp_pkg::CTL_RANGE_LSB])
            dac_code <= clear_code; // [R20]
        end
        dscp_pkg::ADDR_CONFIG: config_word <= frame_data;
        dscp_pkg::ADDR_GAIN: gain_cal <= frame_data;
        dscp_pkg::ADDR_ZERO: zero_cal <= frame_data;
        default: ;
      endcase
    end
  end

  // Command pulses last one mclk cycle
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      watchdog_restart <= 1'b0;
      crc_error_clear <= 1'b0;
    end
    else
    begin
      watchdog_restart <= link.strobe_rise
        && frame_addr == dscp_pkg::ADDR_WD_RESTART; // [R12]
      crc_error_clear <= link.strobe_rise
        && frame_addr == dscp_pkg::ADDR_CRC_CLEAR; // [R12]
    end
  end

  // Readback mux: full codes first, then low-bit matches
  always_comb
  begin
    readback = dscp_pkg::REG_RESET;
    if (frame_data[dscp_pkg::SEL_BITS-1:0] == dscp_pkg::SEL_CONFIG)
      readback = config_word; // [R17]
    else if (frame_data[dscp_pkg::SEL_BITS-1:0] == dscp_pkg::SEL_GAIN)
      readback = gain_cal; // [R17]
    else if (frame_data[dscp_pkg::SEL_BITS-1:0] == dscp_pkg::SEL_ZERO)
      readback = zero_cal; // [R17]
    else if (frame_data[1:0] == dscp_pkg::SEL_STATUS)
      readback = {11'h000, status_flags}; // [R16]
    else if (frame_data[1:0] == dscp_pkg::SEL_DAC)
      readback = dac_code; // [R16]
    else if (frame_data[1:0] == dscp_pkg::SEL_CONTROL)
      readback = control_word; // [R16]
  end

  // Output shifter; a host that skips the idle frame reads stale bits
  always_ff @(posedge mclk)
  begin
    if (rst)
      out_shift <= dscp_pkg::SHIFT_RESET;
    else if (link.strobe_rise)
      out_shift <= (frame_addr == dscp_pkg::ADDR_READ)
        ? {readback, dscp_pkg::PAD_BYTE} // [R13] [R14]
        : dscp_pkg::SHIFT_RESET;
    else if (link.clk_fall)
      out_shift <= {out_shift[dscp_pkg::FRAME_BITS-2:0], 1'b0}; // [R15]
  end

  // Pin follows the shifter MSB through one flop
  always_ff @(posedge mclk)
  begin
    if (rst)
      serial_out <= 1'b0;
    else
      serial_out <= out_shift[dscp_pkg::FRAME_BITS-1]; // [R15]
  end

  // Span decode, registered
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      voltage_output_enable <= 1'b0;
      voltage_span <= dscp_pkg::RANGE_0_5V;
      current_output_enable <= 1'b0;
      current_span_select <= dscp_pkg::ISPAN_OFF;
      modem_inject_enable <= 1'b0;
    end
    else if (dual_output_enable)
    begin
      // Voltage from control, current from config [R01]
      voltage_span <= control_word[dscp_pkg::CTL_RANGE_MSB:
        dscp_pkg::CTL_RANGE_LSB];
      voltage_output_enable <= control_word[dscp_pkg::CTL_OUTEN]
        && !control_word[dscp_pkg::CTL_RANGE_MSB]; // [R02]
      current_span_select <= config_word[dscp_pkg::CFG_ISPAN_MSB:
        dscp_pkg::CFG_ISPAN_LSB];
      current_output_enable <= control_word[dscp_pkg::CTL_OUTEN]
        && config_word[dscp_pkg::CFG_ISPAN_MSB:dscp_pkg::CFG_ISPAN_LSB]
        != dscp_pkg::ISPAN_OFF; // [R04]
      modem_inject_enable <= control_word[dscp_pkg::CTL_OUTEN]
        && config_word[dscp_pkg::CFG_ISPAN_MSB:dscp_pkg::CFG_ISPAN_LSB]
        == dscp_pkg::ISPAN_4_20MA; // [R05]
    end
    else
    begin
      // One range field picks either a voltage or a current span
      voltage_span <= control_word[dscp_pkg::CTL_RANGE_MSB:
        dscp_pkg::CTL_RANGE_LSB];
      voltage_output_enable <= control_word[dscp_pkg::CTL_OUTEN]
        && !control_word[dscp_pkg::CTL_RANGE_MSB];
      current_output_enable <= control_word[dscp_pkg::CTL_OUTEN]
        && control_word[dscp_pkg::CTL_RANGE_MSB];
      unique case (control_word[dscp_pkg::CTL_RANGE_MSB:
        dscp_pkg::CTL_RANGE_LSB])
        dscp_pkg::RANGE_4_20MA: current_span_select <= dscp_pkg::ISPAN_4_20MA;
        dscp_pkg::RANGE_0_20MA: current_span_select <= dscp_pkg::ISPAN_0_20MA;
        dscp_pkg::RANGE_0_24MA: current_span_select <= dscp_pkg::ISPAN_0_24MA;
        default: current_span_select <= dscp_pkg::ISPAN_OFF;
      endcase
      modem_inject_enable <= control_word[dscp_pkg::CTL_OUTEN]
        && control_word[dscp_pkg::CTL_RANGE_MSB:dscp_pkg::CTL_RANGE_LSB]
        == dscp_pkg::RANGE_4_20MA; // [R05]
    end
  end
endmodule // dscp_top

// >>> design/dscp_pkg.sv
// Constants shared by the serial command port design
package dscp_pkg;
  // Frame layout
  localparam int FRAME_BITS = 24;
  localparam int ADDR_MSB = 23;
  localparam int ADDR_LSB = 16;
  localparam int WORD_BITS = 16;
  localparam logic [23:0] SHIFT_RESET = 24'h000000;
  localparam logic [7:0] PAD_BYTE = 8'h00;

  // Write function addresses
  localparam logic [7:0] ADDR_IDLE = 8'h00;
  localparam logic [7:0] ADDR_DAC_DATA = 8'h01;
  localparam logic [7:0] ADDR_READ = 8'h02;
  localparam logic [7:0] ADDR_CONTROL = 8'h55;
  localparam logic [7:0] ADDR_RESET = 8'h56;
  localparam logic [7:0] ADDR_CONFIG = 8'h57;
  localparam logic [7:0] ADDR_GAIN = 8'h58;
  localparam logic [7:0] ADDR_ZERO = 8'h59;
  localparam logic [7:0] ADDR_WD_RESTART = 8'h95;
  localparam logic [7:0] ADDR_CRC_CLEAR = 8'h96;

  // Readback select field
  localparam int SEL_BITS = 6;
  localparam logic [1:0] SEL_STATUS = 2'h0;
  localparam logic [1:0] SEL_DAC = 2'h1;
  localparam logic [1:0] SEL_CONTROL = 2'h2;
  localparam logic [5:0] SEL_CONFIG = 6'h0B;
  localparam logic [5:0] SEL_GAIN = 6'h13;
  localparam logic [5:0] SEL_ZERO = 6'h17;

  // Control register fields
  localparam int CTL_CLRSEL = 15;
  localparam int CTL_OUTEN = 12;
  localparam int CTL_RANGE_MSB = 2;
  localparam int CTL_RANGE_LSB = 0;
  // Configuration register fields
  localparam int CFG_ISPAN_MSB = 10;
  localparam int CFG_ISPAN_LSB = 9;
  localparam int CFG_DUAL = 8;
  // Reset command bit
  localparam int RST_BIT = 0;

  // Span codes
  localparam logic [2:0] RANGE_0_5V = 3'h0;
  localparam logic [2:0] RANGE_0_10V = 3'h1;
  localparam logic [2:0] RANGE_PM5V = 3'h2;
  localparam logic [2:0] RANGE_PM10V = 3'h3;
  localparam logic [2:0] RANGE_FORBIDDEN = 3'h4;
  localparam logic [2:0] RANGE_4_20MA = 3'h5;
  localparam logic [2:0] RANGE_0_20MA = 3'h6;
  localparam logic [2:0] RANGE_0_24MA = 3'h7;
  localparam logic [1:0] ISPAN_OFF = 2'h0;
  localparam logic [1:0] ISPAN_4_20MA = 2'h1;
  localparam logic [1:0] ISPAN_0_20MA = 2'h2;
  localparam logic [1:0] ISPAN_0_24MA = 2'h3;

  // Reset and clear values
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID = 16'h8000;

  // Link rate ceiling
  localparam int LINK_MAX_MHZ = 30;
endpackage

// >>> design/dscp_link_if.sv
// Sampled link events passed from the pin sampler to the command core
`timescale 1ns/10ps
interface dscp_link_if;
  logic clk_rise;
  logic clk_fall;
  logic strobe_rise;
  logic data_bit;

  modport sampler (output clk_rise, output clk_fall, output strobe_rise,
    output data_bit);
  modport core (input clk_rise, input clk_fall, input strobe_rise,
    input data_bit);
endinterface

// >>> design/dscp_sampler.sv
// Pin synchronisers and edge finders for the serial link
`timescale 1ns/10ps
module dscp_sampler
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Raw pins
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic frame_strobe,
  // Sampled events
  dscp_link_if.sampler link
);
  logic [1:0] sync_clk;
  logic [1:0] sync_in;
  logic [1:0] sync_strobe;
  logic last_clk;
  logic last_strobe;

  // Two stages per pin; only the second stage is read
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sync_clk <= 2'h0;
      sync_in <= 2'h0;
      sync_strobe <= 2'h0;
    end
    else
    begin
      sync_clk <= {sync_clk[0], serial_clk};
      sync_in <= {sync_in[0], serial_in};
      sync_strobe <= {sync_strobe[0], frame_strobe};
    end
  end

  // History for edge finding
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      last_clk <= 1'b0;
      last_strobe <= 1'b0;
    end
    else
    begin
      last_clk <= sync_clk[1];
      last_strobe <= sync_strobe[1];
    end
  end

  // Data bit is aligned with the clock edge it is taken on
  assign link.clk_rise = sync_clk[1] & ~last_clk;
  assign link.clk_fall = ~sync_clk[1] & last_clk;
  assign link.strobe_rise = sync_strobe[1] & ~last_strobe;
  assign link.data_bit = sync_in[1];
endmodule // dscp_sampler

// >>> verif/dscp_host.sv
// Host serial master model on the link pins
`timescale 1ns/10ps
module dscp_host
(
  // Link pins
  output logic serial_clk = 1'b0,
  output logic serial_in = 1'b0,
  output logic frame_strobe = 1'b0,
  input wire logic serial_out
);
  // MSB first at 5 MHz; clock idles low
  task xfer(input logic [23:0] f, input int n, output logic [23:0] r);
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_in = f[i]; // Data bit
      #100 serial_clk = 1'b1; // Rise
      #100 r[i] = serial_out;
      serial_clk = 1'b0;
    end
    serial_in = ~serial_in; // No stale data
    #100 frame_strobe = 1'b1; // Commit
    #200 frame_strobe = 1'b0;
    #300;
  endtask
endmodule // dscp_host

// >>> verif/dscp_checker.sv
// Assertions on the command front end ports
`timescale 1ns/10ps
module dscp_checker
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Strobe and registers
  input wire logic frame_strobe,
  input wire logic [15:0] control_word,
  input wire logic [15:0] config_word,
  input wire logic [15:0] dac_code,
  // Spans and pulses
  input wire logic voltage_output_enable,
  input wire logic current_output_enable,
  input wire logic [1:0] current_span_select,
  input wire logic modem_inject_enable,
  input wire logic watchdog_restart,
  input wire logic crc_error_clear
);
  // Decode wanted; outputs trail registers by a cycle
  wire logic dual = config_word[8] & control_word[12];
  wire logic mod_ok = control_word[12] &
    (config_word[8] ? config_word[10:9] == 2'h1 : control_word[2:0] == 3'h5);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_rst;
    $fell(rst) |-> (control_word | config_word | dac_code) == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("not clear");
  property p_forbid; control_word[2:0] != 3'h4; endproperty
  a_forbid: assert property (p_forbid) else $error("bad span");
  property p_vdual;
    $past(dual) |-> voltage_output_enable == !$past(control_word[2]);
  endproperty
  a_vdual: assert property (p_vdual) else $error("volt");
  property p_idual;
    $past(dual) |-> current_span_select == $past(config_word[10:9])
      && current_output_enable == ($past(config_word[10:9]) != 2'h0);
  endproperty
  a_idual: assert property (p_idual) else $error("cur");
  property p_mod; modem_inject_enable == $past(mod_ok); endproperty
  a_mod: assert property (p_mod) else $error("inject");
  property p_wd; watchdog_restart |=> !watchdog_restart; endproperty
  a_wd: assert property (p_wd) else $error("restart");
  property p_crc;
    crc_error_clear |-> !watchdog_restart ##1 !crc_error_clear;
  endproperty
  a_crc: assert property (p_crc) else $error("crc");
  property p_commit;
    $changed(dac_code) || $changed(control_word) |-> $past(frame_strobe, 2);
  endproperty
  a_commit: assert property (p_commit) else $error("commit");
  c_dual: cover property (dual ##2 current_output_enable);
  c_mod: cover property (modem_inject_enable);
  c_wd: cover property (watchdog_restart);
endmodule // dscp_checker

bind dscp_top dscp_checker dscp_checker_i (.mclk, .rst, .frame_strobe,
  .control_word, .config_word, .dac_code, .voltage_output_enable,
  .current_output_enable, .current_span_select, .modem_inject_enable,
  .watchdog_restart, .crc_error_clear);

// >>> verif/dscp_top_test.sv
// Self-checking bench for the serial command front end
`timescale 1ns/10ps
module dscp_top_test;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] status_flags = 5'h15;
  logic serial_clk, serial_in, frame_strobe, serial_out;
  logic [15:0] control_word, config_word, dac_code, gain_cal, zero_cal;
  logic voltage_output_enable, current_output_enable, modem_inject_enable;
  logic [2:0] voltage_span;
  logic [1:0] current_span_select;
  logic watchdog_restart, crc_error_clear;
  logic [23:0] pulses = 24'h000000;
  logic [23:0] r;
  logic [15:0] sel [6] = '{16'h003C, 16'hFFC1, 16'h00FE, 16'h000B,
    16'hFFD3, 16'h0017};
  logic [15:0] want [6] = '{16'h000A, 16'h2468, 16'h1005, 16'h0600,
    16'hA5C3, 16'h5A3C};
  int fail_count = 0;
  int num_checks = 0;
  dscp_top dscp_top_i (.mclk, .rst, .serial_clk, .serial_in, .frame_strobe,
    .serial_out, .status_flags, .control_word, .config_word, .dac_code,
    .gain_cal, .zero_cal, .voltage_output_enable, .voltage_span,
    .current_output_enable, .current_span_select, .modem_inject_enable,
    .watchdog_restart, .crc_error_clear);
  dscp_host dscp_host_i (.serial_clk, .serial_in, .frame_strobe,
    .serial_out);
  // 40 MHz clock
  always #12.5 mclk = ~mclk;
  // Restart pulses count two, clear pulses one; idle in reset, when the
  // pulse flops may still be unknown and would poison the count
  always @(posedge mclk)
    if (!rst)
      pulses <= pulses + {22'h0, watchdog_restart, crc_error_clear};
  task chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %h, expected %h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("%0d checks, %0d wrong", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task fr(input logic [23:0] f);
    dscp_host_i.xfer(f, 24, r);
  endtask
  task do_rst;
    rst = 1'b1;
    repeat (4) @(posedge mclk);
    #1 rst = 1'b0;
  endtask
  // Leftover bits must not survive a reset
  task t_boot;
    chk(control_word | config_word | dac_code, 24'h0);
    dscp_host_i.xfer(24'h005500, 16, r);
    do_rst;
    dscp_host_i.xfer(24'h000007, 8, r);
    chk(control_word, 24'h0);
    $display("boot done");
  endtask
  task t_write;
    fr(24'h551001);
    chk(control_word, 24'h1001);
    fr(24'h01ABCD);
    chk(dac_code, 24'hABCD);
    fr(24'h58A5C3);
    fr(24'h595A3C);
    chk({gain_cal, zero_cal[15:8]}, 24'hA5C35A);
    fr(24'h33FFFF);
    chk(dac_code | control_word, 24'hBBCD);
    fr(24'h950000);
    fr(24'h960000);
    chk(pulses, 24'h3);
    $display("write done");
  endtask
  task t_span;
    fr(24'h559004);
    chk({control_word, dac_code[7:0]}, 24'h9001CD);
    fr(24'h559003);
    chk(dac_code, 24'h0);
    fr(24'h011234);
    fr(24'h551002);
    chk(dac_code, 24'h8000);
    $display("span done");
  endtask
  task t_dual;
    for (int i = 0; i < 4; i++)
    begin
      fr({8'h57, 5'h00, i[1:0], 9'h100});
      chk({voltage_output_enable, voltage_span, current_output_enable,
        current_span_select, modem_inject_enable},
        {1'b1, 3'h2, i != 0, i[1:0], i == 1});
    end
    fr(24'h551005);
    chk(voltage_output_enable, 24'h0);
    fr(24'h570000);
    chk(modem_inject_enable, 24'h1);
    $display("dual done");
  endtask
  task t_read;
    status_flags = 5'h0A;
    fr(24'h570600);
    fr(24'h012468);
    for (int i = 0; i < 6; i++)
    begin
      fr({8'h02, sel[i]});
      fr(24'h000000); // Idle frame
      chk(r, {want[i], 8'h00});
    end
    fr(24'h560001);
    chk(control_word | config_word | gain_cal, 24'h0);
    $display("read done");
  endtask
  // Hang guard
  initial
  begin
    #1000000;
    fail_count++;
    close_out;
  end
  initial
  begin
    do_rst;
    t_boot;
    t_write;
    t_span;
    t_dual;
    t_read;
    close_out;
  end
endmodule // dscp_top_test
